// File: hw/bus_reset_timer.sv
// Timer that holds bus reset signalling for a fixed count of cycles
`timescale 1ns/1ps
`default_nettype none
module bus_reset_timer
  import phy_cfg_pkg::*;
#(
  parameter int unsigned CYCLES = BUS_RESET_CYC
) (
  input  wire logic clk,
  input  wire logic rst_n,
  cfg_link_if.timer tmr
);
  typedef enum logic [1:0] {
    T_IDLE = 2'b01,
    T_RUN  = 2'b10
  } tmr_state_e;

  localparam logic [15:0] LAST_CNT = 16'(CYCLES - 1);

  tmr_state_e  state_r;
  tmr_state_e  state_nxt;
  logic [15:0] cnt_r;
  logic [15:0] cnt_nxt;
  logic        done_nxt;
  logic        done_r;

  // A start while running is ignored, so the pulse never stretches
  always_comb begin
    state_nxt = state_r;
    cnt_nxt   = cnt_r;
    done_nxt  = 1'b0;
    case (state_r)
      T_IDLE: begin
        if (tmr.start) begin
          state_nxt = T_RUN;
          cnt_nxt   = 16'h0000;
        end
      end
      T_RUN: begin
        if (cnt_r == LAST_CNT) begin
          state_nxt = T_IDLE;
          done_nxt  = 1'b1;
        end else begin
          cnt_nxt = cnt_r + 16'h0001;
        end
      end
      default: state_nxt = T_IDLE;
    endcase
  end

  // State registers
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_r <= T_IDLE;
      cnt_r   <= 16'h0000;
      done_r  <= 1'b0;
    end else begin
      state_r <= state_nxt;
      cnt_r   <= cnt_nxt;
      done_r  <= done_nxt;
    end
  end

  assign tmr.busy = (state_r == T_RUN);
  assign tmr.done = done_r;
endmodule
`default_nettype wire

// File: hw/cfg_link_if.sv
// Carrier between the register bank, its reset timer and its read mux
`timescale 1ns/1ps
`default_nettype none
interface cfg_link_if;
  import phy_cfg_pkg::*;
  logic                start;
  logic                busy;
  logic                done;
  logic [DATA_W-1:0]   regs [NUM_REGS];
  logic [ADDR_W-1:0]   addr;
  logic [DATA_W-1:0]   rdata;

  modport owner (output start, input busy, input done,
                 output regs, output addr, input rdata);
  modport timer (input start, output busy, output done);
  modport mux   (input regs, input addr, output rdata);
endinterface
`default_nettype wire

// File: hw/cfg_read_mux.sv
// Read multiplexer for the configuration register map
`timescale 1ns/1ps
`default_nettype none
module cfg_read_mux
  import phy_cfg_pkg::*;
(
  cfg_link_if.mux rd
);
  // Unmapped addresses read as zero rather than alias a register
  function automatic logic in_map(input logic [ADDR_W-1:0] a);
    return (32'(a) < NUM_REGS);
  endfunction

  always_comb begin
    rd.rdata = BYTE_ZERO;
    if (in_map(rd.addr)) begin
      rd.rdata = rd.regs[rd.addr];
    end
  end
endmodule
`default_nettype wire

// File: hw/phy_cfg_pkg.sv
// Constants shared by the physical layer configuration register bank
package phy_cfg_pkg;
  // Map size and address width
  localparam int unsigned NUM_REGS  = 10;
  localparam int unsigned ADDR_W    = 4;
  localparam int unsigned DATA_W    = 8;

  // Register offsets
  localparam logic [3:0] ADDR_NODE_ID   = 4'h0;
  localparam logic [3:0] ADDR_XCVR_CTRL = 4'h1;
  localparam logic [3:0] ADDR_LAST_WIN  = 4'h2;
  localparam logic [3:0] ADDR_LINE_SPD  = 4'h3;
  localparam logic [3:0] ADDR_PRIORITY  = 4'h4;
  localparam logic [3:0] ADDR_PROD_TEST = 4'h5;
  localparam logic [3:0] ADDR_REQ_FMT   = 4'h6;
  localparam logic [3:0] ADDR_LINE_CTRL = 4'h7;
  localparam logic [3:0] ADDR_TEST_A    = 4'h8;
  localparam logic [3:0] ADDR_TEST_B    = 4'h9;

  // Field positions; bit 0 of the map is the LSB of the byte
  localparam int unsigned NODE_ID_LSB   = 2;
  localparam int unsigned NODE_ID_W     = 6;
  localparam int unsigned NODE_TEST_W   = 2;
  localparam int unsigned BIT_TD        = 7;
  localparam int unsigned BIT_IBR       = 6;
  localparam int unsigned BIT_ENH       = 0;
  localparam int unsigned BIT_RX_DATA   = 7;
  localparam int unsigned BIT_RX_STRB   = 6;
  localparam int unsigned SPD_LSB       = 4;
  localparam int unsigned SPD_W         = 2;
  localparam int unsigned PRI_LSB       = 4;
  localparam int unsigned PRI_W         = 4;
  localparam int unsigned PROD_LSB      = 4;
  localparam int unsigned PROD_TEST_W   = 4;
  localparam int unsigned BIT_EBLREQ    = 7;
  localparam int unsigned BIT_ARBITRATED_RESET_REQUEST      = 6;
  localparam int unsigned BIT_STATE_MACHINE_RESTART     = 5;
  localparam int unsigned BIT_SOFTWARE_HARD_RESET    = 4;
  localparam int unsigned LINE_CTRL_LSB = 5;
  localparam int unsigned LINE_CTRL_W   = 3;
  localparam int unsigned BIT_TX_DATA   = 3;
  localparam int unsigned BIT_TX_STRB   = 2;
  localparam int unsigned BIT_TRI_OE    = 1;
  localparam int unsigned BIT_OC_OE     = 0;

  // Fixed read values
  localparam logic       ENH_MAP_FLAG   = 1'b1;
  localparam logic [3:0] ENH_REG_COUNT  = 4'h5;
  // Product code; value is arbitrary
  localparam logic [3:0] PRODUCT_CODE   = 4'h0;

  // Power-up values
  localparam logic [7:0] BYTE_ZERO      = 8'h00;
  localparam logic [5:0] NODE_ID_RST    = 6'h00;
  localparam logic [3:0] PRI_RST        = 4'h0;

  // Bus reset signalling length
  localparam int unsigned CLK_PERIOD_NS  = 10;
  localparam int unsigned BUS_RESET_NS   = 8000;
  localparam int unsigned BUS_RESET_CYC  = BUS_RESET_NS / CLK_PERIOD_NS;
endpackage

// File: hw/phy_cfg_regs.sv
// Configuration register bank of a backplane serial bus physical layer
`timescale 1ns/1ps
`default_nettype none

// Notes on behaviour
// - Ten byte registers, addresses 0 to 9
// - Reserved bits and fields read as zero
// - Six-bit writable node id, loaded from pins after power-up
// - Hard resets reload node id from pins
// - Bus and state resets keep node id
// - Disable bit switches transceiver enables off
// - Disabled: ignore actions changing bus output
// - Disable bit zero at power-up, kept otherwise
// - Immediate reset bit starts signalling unarbitrated
// - Reset held about 8 us, bit self-clears
module phy_cfg_regs
  import phy_cfg_pkg::*;
#(
  parameter int unsigned RESET_CYCLES = BUS_RESET_CYC
) (
  input  wire logic                         clk,
  input  wire logic                         rst_n,
  input  wire logic                         req_valid,
  input  wire logic                         req_write,
  input  wire logic [phy_cfg_pkg::ADDR_W-1:0] req_addr,
  input  wire logic [phy_cfg_pkg::DATA_W-1:0] req_wdata,
  output logic      [phy_cfg_pkg::DATA_W-1:0] rd_data,
  output logic                              rd_valid,
  input  wire logic [5:0]                   id_pins,
  input  wire logic [3:0]                   pri_pins,
  input  wire logic [1:0]                   speed_pins,
  input  wire logic                         rx_data_line,
  input  wire logic                         rx_strobe_line,
  input  wire logic                         tx_data_line,
  input  wire logic                         tx_strobe_line,
  input  wire logic                         tri_drive_req,
  input  wire logic                         oc_drive_req,
  input  wire logic [5:0]                   win_node_id,
  input  wire logic [3:0]                   win_priority,
  output logic      [5:0]                   node_identifier,
  output logic      [3:0]                   priority_level,
  output logic                              transceiver_disable,
  output logic                              bus_reset_active,
  output logic                              arbitrated_reset_request,
  output logic                              state_machine_restart,
  output logic                              backplane_request_format,
  output logic      [2:0]                   line_ctrl,
  output logic                              tri_oe,
  output logic                              oc_oe
);

  cfg_link_if link ();

  ////////////////////////////////////////////////////////////////////////////
  // Register state

  logic [NODE_ID_W-1:0]   node_id_r,   node_id_nxt;
  logic [NODE_TEST_W-1:0] node_tst_r,  node_tst_nxt;
  logic                   td_r,        td_nxt;
  logic                   ibr_r,       ibr_nxt;
  logic [PRI_W-1:0]       pri_r,       pri_nxt;
  logic [SPD_W-1:0]       spd_r,       spd_nxt;
  logic [PROD_TEST_W-1:0] prod_tst_r,  prod_tst_nxt;
  logic                   ebl_r,       ebl_nxt;
  logic                   arbitrated_reset_request_r,      arbitrated_reset_request_nxt;
  logic                   state_machine_restart_r,     state_machine_restart_nxt;
  logic [LINE_CTRL_W-1:0] lctl_r,      lctl_nxt;
  logic [DATA_W-1:0]      test_a_r,    test_a_nxt;
  logic [DATA_W-1:0]      test_b_r,    test_b_nxt;
  logic                   hard_load_r, hard_load_nxt;
  logic [DATA_W-1:0]      rd_data_r,   rd_data_nxt;
  logic                   rd_valid_r,  rd_valid_nxt;
  logic                   tri_oe_r,    tri_oe_nxt;
  logic                   oc_oe_r,     oc_oe_nxt;
  logic                   wr_en;

  // Decode a write to one offset
  function automatic logic wr_hit(input logic             en,
                                  input logic [ADDR_W-1:0] a,
                                  input logic [3:0]        offs);
    return en && (a == offs);
  endfunction

  assign wr_en = req_valid && req_write;

  ////////////////////////////////////////////////////////////////////////////
  // Next-state logic

  // One process owns every writable field so priorities stay visible
  always_comb begin
    node_id_nxt   = node_id_r;
    node_tst_nxt  = node_tst_r;
    td_nxt        = td_r;
    ibr_nxt       = ibr_r;
    pri_nxt       = pri_r;
    spd_nxt       = spd_r;
    prod_tst_nxt  = prod_tst_r;
    ebl_nxt       = ebl_r;
    arbitrated_reset_request_nxt      = 1'b0;
    state_machine_restart_nxt     = 1'b0;
    lctl_nxt      = lctl_r;
    test_a_nxt    = test_a_r;
    test_b_nxt    = test_b_r;
    hard_load_nxt = 1'b0;
    link.start    = 1'b0;

    // Ordinary register writes take effect on the request edge
    if (wr_hit(wr_en, req_addr, ADDR_NODE_ID)) begin
      node_id_nxt  = req_wdata[NODE_ID_LSB +: NODE_ID_W];
      node_tst_nxt = req_wdata[NODE_TEST_W-1:0];
    end
    if (wr_hit(wr_en, req_addr, ADDR_XCVR_CTRL)) begin
      td_nxt = req_wdata[BIT_TD];
      // Immediate reset skips arbitration; refused while disabled
      if (req_wdata[BIT_IBR] && !td_r && !link.busy) begin
        ibr_nxt    = 1'b1;
        link.start = 1'b1;
      end
    end
    if (wr_hit(wr_en, req_addr, ADDR_PRIORITY)) begin
      pri_nxt = req_wdata[PRI_LSB +: PRI_W];
    end
    if (wr_hit(wr_en, req_addr, ADDR_PROD_TEST)) begin
      prod_tst_nxt = req_wdata[PROD_TEST_W-1:0];
    end
    if (wr_hit(wr_en, req_addr, ADDR_REQ_FMT)) begin
      ebl_nxt   = req_wdata[BIT_EBLREQ];
      // Arbitrated reset also drives the bus, so it is refused too
      arbitrated_reset_request_nxt  = req_wdata[BIT_ARBITRATED_RESET_REQUEST] && !td_r;
      // State machine restart leaves the node id alone
      state_machine_restart_nxt = req_wdata[BIT_STATE_MACHINE_RESTART];
      hard_load_nxt = req_wdata[BIT_SOFTWARE_HARD_RESET];
    end
    if (wr_hit(wr_en, req_addr, ADDR_LINE_CTRL)) begin
      lctl_nxt = req_wdata[LINE_CTRL_LSB +: LINE_CTRL_W];
    end
    if (wr_hit(wr_en, req_addr, ADDR_TEST_A)) begin
      test_a_nxt = req_wdata;
    end
    if (wr_hit(wr_en, req_addr, ADDR_TEST_B)) begin
      test_b_nxt = req_wdata;
    end

    // Reset signalling ended: the request bit clears itself
    if (link.done) begin
      ibr_nxt = 1'b0;
    end

    // Hard reload from pins beats a same-cycle software write
    if (hard_load_r) begin
      node_id_nxt = id_pins;
      pri_nxt     = pri_pins;
      spd_nxt     = speed_pins;
      ebl_nxt     = 1'b0;
    end
  end

  // Bus output enables; dropped on the edge after the disable bit is set
  always_comb begin
    tri_oe_nxt = (tri_drive_req || link.busy) && !td_r;
    oc_oe_nxt  = (oc_drive_req || link.busy) && !td_r;
  end

  // Read sample: contents as they stand on the request edge
  always_comb begin
    link.addr    = req_addr;
    rd_valid_nxt = req_valid && !req_write;
    rd_data_nxt  = rd_data_r;
    if (rd_valid_nxt) begin
      rd_data_nxt = link.rdata;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read view; reserved bits are tied to zero here

  always_comb begin
    for (int i = 0; i < NUM_REGS; i++) begin
      link.regs[i] = BYTE_ZERO;
    end
    link.regs[ADDR_NODE_ID][NODE_ID_LSB +: NODE_ID_W] = node_id_r;
    link.regs[ADDR_NODE_ID][NODE_TEST_W-1:0]          = node_tst_r;
    link.regs[ADDR_XCVR_CTRL][BIT_TD]                 = td_r;
    link.regs[ADDR_XCVR_CTRL][BIT_IBR]                = ibr_r;
    link.regs[ADDR_LAST_WIN][NODE_ID_LSB +: NODE_ID_W] = win_node_id;
    link.regs[ADDR_LAST_WIN][BIT_ENH]                 = ENH_MAP_FLAG;
    link.regs[ADDR_LINE_SPD][BIT_RX_DATA]             = rx_data_line;
    link.regs[ADDR_LINE_SPD][BIT_RX_STRB]             = rx_strobe_line;
    link.regs[ADDR_LINE_SPD][SPD_LSB +: SPD_W]        = spd_r;
    link.regs[ADDR_LINE_SPD][PRI_W-1:0]               = ENH_REG_COUNT;
    link.regs[ADDR_PRIORITY][PRI_LSB +: PRI_W]        = pri_r;
    link.regs[ADDR_PROD_TEST][PROD_LSB +: PRI_W]      = PRODUCT_CODE;
    link.regs[ADDR_PROD_TEST][PROD_TEST_W-1:0]        = prod_tst_r;
    // Self-clearing strobes and the hard reset bit read back as zero
    link.regs[ADDR_REQ_FMT][BIT_EBLREQ]               = ebl_r;
    link.regs[ADDR_REQ_FMT][PRI_W-1:0]                = win_priority;
    link.regs[ADDR_LINE_CTRL][LINE_CTRL_LSB +: LINE_CTRL_W] = lctl_r;
    link.regs[ADDR_LINE_CTRL][BIT_TX_DATA]            = tx_data_line;
    link.regs[ADDR_LINE_CTRL][BIT_TX_STRB]            = tx_strobe_line;
    link.regs[ADDR_LINE_CTRL][BIT_TRI_OE]             = tri_oe_r;
    link.regs[ADDR_LINE_CTRL][BIT_OC_OE]              = oc_oe_r;
    link.regs[ADDR_TEST_A]                            = test_a_r;
    link.regs[ADDR_TEST_B]                            = test_b_r;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Registers

  // Pins are caught one edge after release, never under reset itself
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      node_id_r   <= NODE_ID_RST;
      node_tst_r  <= '0;
      td_r        <= 1'b0;
      ibr_r       <= 1'b0;
      pri_r       <= PRI_RST;
      spd_r       <= '0;
      prod_tst_r  <= '0;
      ebl_r       <= 1'b0;
      arbitrated_reset_request_r      <= 1'b0;
      state_machine_restart_r     <= 1'b0;
      lctl_r      <= '0;
      test_a_r    <= BYTE_ZERO;
      test_b_r    <= BYTE_ZERO;
      hard_load_r <= 1'b1;
      rd_data_r   <= BYTE_ZERO;
      rd_valid_r  <= 1'b0;
      tri_oe_r    <= 1'b0;
      oc_oe_r     <= 1'b0;
    end else begin
      node_id_r   <= node_id_nxt;
      node_tst_r  <= node_tst_nxt;
      td_r        <= td_nxt;
      ibr_r       <= ibr_nxt;
      pri_r       <= pri_nxt;
      spd_r       <= spd_nxt;
      prod_tst_r  <= prod_tst_nxt;
      ebl_r       <= ebl_nxt;
      arbitrated_reset_request_r      <= arbitrated_reset_request_nxt;
      state_machine_restart_r     <= state_machine_restart_nxt;
      lctl_r      <= lctl_nxt;
      test_a_r    <= test_a_nxt;
      test_b_r    <= test_b_nxt;
      hard_load_r <= hard_load_nxt;
      rd_data_r   <= rd_data_nxt;
      rd_valid_r  <= rd_valid_nxt;
      tri_oe_r    <= tri_oe_nxt;
      oc_oe_r     <= oc_oe_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Helpers and outputs

  bus_reset_timer #(
    .CYCLES (RESET_CYCLES)
  ) u_timer (
    .clk   (clk),
    .rst_n (rst_n),
    .tmr   (link.timer)
  );

  cfg_read_mux u_mux (
    .rd (link.mux)
  );

  // Reset signalling stops at once if the transceiver is disabled
  assign bus_reset_active         = ibr_r && !td_r;
  assign node_identifier          = node_id_r;
  assign priority_level           = pri_r;
  assign transceiver_disable      = td_r;
  assign arbitrated_reset_request = arbitrated_reset_request_r;
  assign state_machine_restart    = state_machine_restart_r;
  assign backplane_request_format = ebl_r;
  assign line_ctrl                = lctl_r;
  assign tri_oe                   = tri_oe_r;
  assign oc_oe                    = oc_oe_r;
  assign rd_data                  = rd_data_r;
  assign rd_valid                 = rd_valid_r;
endmodule
`default_nettype wire

// File: test/llc_model.sv
// Link layer controller model issuing register service requests
`timescale 1ns/1ps
`default_nettype none
module llc_model (
  input  wire logic       clk,
  input  wire logic [7:0] rd_data,
  input  wire logic       rd_valid,
  output logic            req_valid,
  output logic            req_write,
  output logic [3:0]      req_addr,
  output logic [7:0]      req_wdata
);
  // Idle request lines
  initial begin
    req_valid = 1'b0;
    req_write = 1'b0;
    req_addr  = 4'h0;
    req_wdata = 8'h00;
  end
  // Byte write; reserved bits are sent as the caller gives them
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(negedge clk);
    req_valid = 1'b1;
    req_write = 1'b1;
    req_addr  = a;
    req_wdata = d;
    @(negedge clk);
    req_valid = 1'b0;
    req_wdata = ~d;
  endtask
  // Byte read; stale lines inverted so no old value lingers
  task automatic rd(input logic [3:0] a, output logic [7:0] d);
    int n;
    @(negedge clk);
    req_valid = 1'b1;
    req_write = 1'b0;
    req_addr  = a;
    @(negedge clk);
    req_valid = 1'b0;
    req_addr  = ~a;
    n = 0;
    while (rd_valid !== 1'b1 && n < 8) begin
      @(negedge clk);
      n++;
    end
    d = (rd_valid === 1'b1) ? rd_data : 8'hXX;
  endtask
endmodule
`default_nettype wire

// File: test/phy_cfg_checker.sv
// Port-level assertions for the configuration register bank
`timescale 1ns/1ps
`default_nettype none
module phy_cfg_checker
  import phy_cfg_pkg::*;
#(
  parameter int unsigned RESET_CYCLES = 8
) (
  input wire logic       clk,
  input wire logic       rst_n,
  input wire logic       req_valid,
  input wire logic       req_write,
  input wire logic [3:0] req_addr,
  input wire logic [7:0] req_wdata,
  input wire logic [7:0] rd_data,
  input wire logic       rd_valid,
  input wire logic [5:0] id_pins,
  input wire logic [5:0] node_identifier,
  input wire logic       transceiver_disable,
  input wire logic       bus_reset_active,
  input wire logic       arbitrated_reset_request,
  input wire logic       state_machine_restart,
  input wire logic       tri_oe,
  input wire logic       oc_oe
);
  import phy_cfg_pkg::*;
  logic [15:0] hi_cnt_r;
  logic [15:0] hi_cnt_nxt;
  logic        rd_req;
  logic        wr_req;
  // Request decode
  assign rd_req = req_valid && !req_write;
  assign wr_req = req_valid && req_write;
  // Length of the running bus reset; too long to unroll as a repetition
  always_comb begin
    hi_cnt_nxt = bus_reset_active ? hi_cnt_r + 16'h0001 : 16'h0000;
  end
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      hi_cnt_r <= 16'h0000;
    end else begin
      hi_cnt_r <= hi_cnt_nxt;
    end
  end
  default clocking dcb @(posedge clk); endclocking
  default disable iff (!rst_n);
  ////////////////////////////////////////////////////////////////////////////
  property p_rd_answer; rd_req |=> rd_valid; endproperty
  a_rd_answer: assert property (p_rd_answer)
    else $error("read answer missing");
  property p_rd_cause; rd_valid |-> $past(rd_req); endproperty
  a_rd_cause: assert property (p_rd_cause)
    else $error("read answer without request");
  property p_unmapped; rd_req && req_addr > 4'h9 |=> rd_data == 8'h00;
  endproperty
  a_unmapped: assert property (p_unmapped)
    else $error("unmapped read not zero");
  property p_reserved_bits;
    rd_req && req_addr == ADDR_XCVR_CTRL |=> rd_data[5:0] == 6'h00;
  endproperty
  a_reserved_bits: assert property (p_reserved_bits)
    else $error("reserved bits not zero");
  property p_node_wr;
    wr_req && req_addr == ADDR_NODE_ID
      |=> node_identifier == $past(req_wdata[7:2]);
  endproperty
  a_node_wr: assert property (p_node_wr)
    else $error("node id write lost");
  // Reload lands on the edge after the write edge, checked two edges after that
  property p_reload;
    wr_req && req_addr == ADDR_REQ_FMT && req_wdata[4]
      |=> ##2 node_identifier == $past(id_pins);
  endproperty
  a_reload: assert property (p_reload)
    else $error("node id not reloaded from pins");
  property p_keep_id;
    (arbitrated_reset_request || state_machine_restart) && !req_valid
      |=> $stable(node_identifier);
  endproperty
  a_keep_id: assert property (p_keep_id)
    else $error("node id changed by restart");
  property p_oe_off; transceiver_disable [*2] |-> !tri_oe && !oc_oe;
  endproperty
  a_oe_off: assert property (p_oe_off)
    else $error("drive enable while disabled");
  // A request taken while disabled would surface once re-enabled
  property p_quiet; transceiver_disable |=> !$rose(bus_reset_active);
  endproperty
  a_quiet: assert property (p_quiet)
    else $error("bus reset while disabled");
  property p_ibr_start;
    wr_req && req_addr == ADDR_XCVR_CTRL && req_wdata[6] && !req_wdata[7]
      && !transceiver_disable && !bus_reset_active |=> bus_reset_active;
  endproperty
  a_ibr_start: assert property (p_ibr_start)
    else $error("bus reset did not start");
  property p_ibr_len;
    $fell(bus_reset_active) && !transceiver_disable
      |-> hi_cnt_r == RESET_CYCLES + 1;
  endproperty
  a_ibr_len: assert property (p_ibr_len)
    else $error("bus reset length wrong");
endmodule
bind phy_cfg_regs phy_cfg_checker #(.RESET_CYCLES(RESET_CYCLES)) i_chk (
  .clk, .rst_n, .req_valid, .req_write, .req_addr, .req_wdata, .rd_data,
  .rd_valid, .id_pins, .node_identifier, .transceiver_disable,
  .bus_reset_active, .arbitrated_reset_request, .state_machine_restart,
  .tri_oe, .oc_oe
);
`default_nettype wire

// File: test/phy_cfg_regs_tb.sv
// Self-checking testbench of the configuration register bank
`timescale 1ns/1ps
`default_nettype none
`define CHK(got, exp) \
  begin \
    checked++; \
    if ((got) !== (exp)) begin \
      errors++; \
      $display("ERROR at %0t got %h expected %h", $time, got, exp); \
    end \
  end
module phy_cfg_regs_tb;
  import phy_cfg_pkg::*;
  localparam int unsigned RC = 8;
  int         errors, checked, hi_cnt;
  logic       clk, rst_n, req_valid, req_write, rd_valid;
  logic [3:0] req_addr, pri_pins, win_priority;
  logic [7:0] req_wdata, rd_data, d;
  logic [5:0] id_pins, win_node_id, node_identifier;
  logic [1:0] speed_pins;
  logic       rx_d, rx_s, tx_d, tx_s, tri_rq, oc_rq, td, bra;
  logic       arr, smr, t_oe, o_oe;
  logic [3:0] wa [7] = '{4'h0, 4'h8, 4'h9, 4'h4, 4'h1, 4'hC, 4'h5};
  logic [7:0] wd [7] = '{8'hA7, 8'hA5, 8'h5A, 8'hF0, 8'h00, 8'hFF, 8'h3C};
  logic [7:0] we [7] = '{8'hA7, 8'hA5, 8'h5A, 8'hF0, 8'h00, 8'h00, 8'h0C};
  phy_cfg_regs #(.RESET_CYCLES(RC)) i_dut (
    .clk, .rst_n, .req_valid, .req_write, .req_addr, .req_wdata, .rd_data,
    .rd_valid, .id_pins, .pri_pins, .speed_pins, .rx_data_line(rx_d),
    .rx_strobe_line(rx_s), .tx_data_line(tx_d), .tx_strobe_line(tx_s),
    .tri_drive_req(tri_rq), .oc_drive_req(oc_rq), .win_node_id,
    .win_priority, .node_identifier, .priority_level(),
    .transceiver_disable(td), .bus_reset_active(bra),
    .arbitrated_reset_request(arr), .state_machine_restart(smr),
    .backplane_request_format(), .line_ctrl(), .tri_oe(t_oe), .oc_oe(o_oe)
  );
  llc_model i_llc (
    .clk, .rd_data, .rd_valid, .req_valid, .req_write, .req_addr, .req_wdata
  );
  // Expected read of an untouched map, built from the pin levels
  function automatic logic [7:0] exp_rd(input logic [3:0] a);
    case (a)
      4'h0: exp_rd = {id_pins, 2'b00};
      4'h2: exp_rd = {win_node_id, 2'b01};
      4'h3: exp_rd = {rx_d, rx_s, speed_pins, ENH_REG_COUNT};
      4'h4: exp_rd = {pri_pins, 4'h0};
      4'h5: exp_rd = {PRODUCT_CODE, 4'h0};
      4'h6: exp_rd = {4'h0, win_priority};
      4'h7: exp_rd = {4'h0, tx_d, tx_s, 2'b00};
      default: exp_rd = 8'h00;
    endcase
  endfunction
  task automatic report_and_stop();
    $display("errors %0d checked %0d", errors, checked);
    if (errors == 0 && checked > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  // Clock and bus reset cycle counter
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  always @(posedge clk) begin
    if (bra === 1'b1) hi_cnt <= hi_cnt + 1;
  end
  // Watchdog; the whole sequence needs well under a thousand cycles
  initial begin
    #100000;
    errors++;
    report_and_stop();
  end
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    {errors, checked, hi_cnt} = '0;
    {rst_n, tri_rq, oc_rq, rx_d, rx_s, tx_d, tx_s} = 7'b0110101;
    {tri_rq, oc_rq} = 2'b00;
    {id_pins, pri_pins, speed_pins} = {6'h13, 4'h9, 2'b10};
    {win_node_id, win_priority} = {6'h2A, 4'hB};
    repeat (3) @(negedge clk);
    rst_n = 1'b1;
    repeat (2) @(negedge clk);
    // Power-up map, reserved bits and unmapped holes
    for (int a = 0; a < 16; a++) begin
      i_llc.rd(4'(a), d);
      `CHK(d, exp_rd(4'(a)))
    end
    // Writes to writable, mixed and unmapped places, then read back
    for (int i = 0; i < 7; i++) i_llc.wr(wa[i], wd[i]);
    for (int i = 0; i < 7; i++) begin
      i_llc.rd(wa[i], d);
      `CHK(d, we[i])
    end
    // Restart pulses, then an immediate reset and its length in cycles
    i_llc.wr(ADDR_REQ_FMT, 8'h60);
    hi_cnt = 0;
    i_llc.wr(ADDR_XCVR_CTRL, 8'h40);
    i_llc.rd(ADDR_XCVR_CTRL, d);
    `CHK(d, 8'h40)
    repeat (RC + 4) @(negedge clk);
    `CHK(hi_cnt, RC + 1)
    i_llc.rd(ADDR_XCVR_CTRL, d);
    `CHK(d, 8'h00)
    i_llc.rd(ADDR_NODE_ID, d);
    `CHK(d, 8'hA7)
    // Software hard reset reloads node id and priority from pins
    {id_pins, pri_pins} = {6'h2D, 4'h6};
    i_llc.wr(ADDR_REQ_FMT, 8'h10);
    repeat (2) @(negedge clk);
    i_llc.rd(ADDR_NODE_ID, d);
    `CHK(d[7:2], 6'h2D)
    i_llc.rd(ADDR_PRIORITY, d);
    `CHK(d, 8'h60)
    // Enabled transceivers follow the drive requests, disabled ones do not
    {tri_rq, oc_rq} = 2'b11;
    @(negedge clk);
    `CHK({t_oe, o_oe}, 2'b11)
    i_llc.wr(ADDR_XCVR_CTRL, 8'h80);
    repeat (2) @(negedge clk);
    `CHK({t_oe, o_oe}, 2'b00)
    hi_cnt = 0;
    i_llc.wr(ADDR_XCVR_CTRL, 8'hC0);
    repeat (RC + 4) @(negedge clk);
    `CHK(hi_cnt, 0)
    i_llc.rd(ADDR_XCVR_CTRL, d);
    `CHK(d, 8'h80)
    // Second hard reset in mid-run
    rst_n = 1'b0;
    @(negedge clk);
    rst_n = 1'b1;
    repeat (2) @(negedge clk);
    i_llc.rd(ADDR_XCVR_CTRL, d);
    `CHK(d, 8'h00)
    i_llc.rd(ADDR_NODE_ID, d);
    `CHK(d, {6'h2D, 2'b00})
    report_and_stop();
  end
endmodule
`default_nettype wire
